// file: dbpc_pkg.sv
// Constants and types shared by the display back-end pin control block.
// Assumes a 20 MHz system clock and a classic Wishbone register bus.
package dbpc_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] MEAS_OFS = 8'h04;
    localparam logic [7:0] RAMP_OFS = 8'h08;
    localparam logic [7:0] PARAB_OFS = 8'h0C;
    localparam logic [7:0] BEAM_OFS = 8'h10;
    localparam logic [7:0] PORT_OFS = 8'h14;
    localparam logic [7:0] CLUT_OFS = 8'h18;
    localparam logic [7:0] STAT_OFS = 8'h1C;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_STANDBY = 0;
    localparam int CTRL_POL = 1;
    localparam int CTRL_GATE = 2;
    localparam int CTRL_ILACE = 3;
    localparam int CTRL_PORTS = 4;
    localparam int MEAS_CUTOFF = 0;
    localparam int MEAS_WHITE = 1;
    localparam int PORT_DIR_LSB = 8;
    localparam int CLUT_IDX_LSB = 16;
    localparam int STAT_GUARD_EV = 0;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // ------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------
    localparam int DAC_IN_W = 15;
    localparam int DAC_OUT_W = 4;
    localparam int CLUT_W = 12;
    localparam int CLK_PERIOD_NS = 50;
    localparam int LINE_NS = 64000;
    localparam int LINE_PULSE_NS = 28000;
    localparam int LINE_CYC = LINE_NS / CLK_PERIOD_NS;
    localparam int PULSE_CYC = LINE_PULSE_NS / CLK_PERIOD_NS;
    localparam int MCU_HALF_CYC = 2;
    localparam logic [7:0] BEAM_MID = 8'h80;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DBPC_SAFE_NORMAL = 2'b00,
        DBPC_SAFE_BLANK = 2'b01,
        DBPC_SAFE_SHUT = 2'b10
    } dbpc_safe_t;
    typedef struct packed {
        logic standby;
        logic pol;
        logic gate;
        logic ilace;
        logic ports;
    } dbpc_ctrl_t;
    typedef struct packed {
        logic blank;
        logic half;
        logic ext1;
        logic ext2;
        logic [2:0] src;
        logic [CLUT_W-1:0] rgb;
    } dbpc_pix_t;
endpackage : dbpc_pkg

// file: dbpc_shaper.sv
// First-order noise-shaping converter from a wide code to a narrow DAC code.
// Assumes the enable gates updates; the output is held while disabled.
`timescale 1ns/1ps
module dbpc_shaper #(
    parameter int IN_W = 15,
    parameter int OUT_W = 4
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic en_in,
    input wire logic [IN_W-1:0] val_in,
    output logic [OUT_W-1:0] code_out
);
    localparam int ERR_W = IN_W - OUT_W;
    logic [ERR_W-1:0] err_r;
    logic [IN_W:0] acc;

    // Residue is fed back so quantisation noise moves to high frequency
    assign acc = {1'b0, val_in} + {{(OUT_W + 1){1'b0}}, err_r};

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            err_r <= '0;
            code_out <= '0;
        end else if (en_in) begin
            if (acc[IN_W]) begin
                code_out <= '1;
                err_r <= '0;
            end else begin
                code_out <= acc[IN_W-1:ERR_W];
                err_r <= acc[ERR_W-1:0];
            end
        end
    end
endmodule : dbpc_shaper

// file: dbpc_top.sv
// Display back-end pin control: protection blanking, line drive, field
// flag, picture bus sampling, range switches, deflection DACs, clocks,
// port expander and a Wishbone register file.
// Assumes all pin inputs are synchronous to CLK_SYS_IN except the guard
// and safety levels, which are synchronised here.
`timescale 1ns/1ps
module dbpc_top #(
    parameter int LINE_CYCLES = dbpc_pkg::LINE_CYC,
    parameter int PULSE_CYCLES = dbpc_pkg::PULSE_CYC
) (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RESETN_IN,
    // Wishbone slave
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [7:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    // Protection and timing inputs
    input wire logic RAMP_OUT_A_BLANK_IN,
    input wire logic RAMP_OUT_A_GUARD_IN,
    input wire logic [1:0] SAFETY_LEVEL_IN,
    input wire logic LINE_RETRACE_IN,
    // Picture bus and analog switch inputs
    input wire logic [2:0] SOURCE_PRIORITY_LINES_IN,
    input wire logic [1:0] EXT_RGB_SWITCH_IN,
    // Shared port pins: 0 is half level, 2..6 are colour 4..0
    input wire logic [6:0] PORT_PINS_IN,
    output logic [6:0] PORT_PINS_OUT,
    output logic [6:0] PORT_PINS_OE_OUT,
    // Picture output control
    output logic RGB_BLANK_OUT,
    output logic RGB_HALF_LEVEL_OUT,
    output logic [1:0] RGB_EXT_SELECT_OUT,
    output logic [2:0] SOURCE_SELECT_OUT,
    output logic [11:0] RGB_CODE_OUT,
    // Deflection and sync
    output logic FIELD_PARITY_OUT,
    output logic LINE_DRIVE_OUT,
    output logic LINE_DRIVE_OE_OUT,
    output logic [3:0] RAMP_OUT_A_OUT,
    output logic [3:0] PINCUSHION_PARABOLA_OUT,
    output logic [7:0] BEAM_SPEED_MOD_OUT,
    // Measurement range switches, open drain
    output logic MEAS_RANGE_SW_A_OUT,
    output logic MEAS_RANGE_SW_A_OE_OUT,
    output logic MEAS_RANGE_SW_B_OUT,
    output logic MEAS_RANGE_SW_B_OE_OUT,
    // Clock outputs
    output logic SYS_CLK_OUT,
    output logic MCU_CLK_OUT
);
    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    dbpc_pkg::dbpc_ctrl_t ctrl_r;
    logic [1:0] meas_r;
    logic [14:0] ramp_r;
    logic [14:0] parab_r;
    logic [7:0] beam_r;
    logic [6:0] port_dat_r;
    logic [6:0] port_dir_r;
    logic guard_ev_r;
    logic [11:0] clut [0:31];
    logic wb_req;
    logic wb_wr;
    logic [31:0] wmask;
    logic [31:0] rdata;
    logic [31:0] ctrl_word;
    logic [31:0] ctrl_new;

    assign wb_req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
    // Write lands at the edge where the master samples ack
    assign wb_wr = WB_CYC_IN && WB_STB_IN && WB_WE_IN && WB_ACK_OUT;

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_mask
            assign wmask[gb*8 +: 8] = {8{WB_SEL_IN[gb]}};
        end
    endgenerate

    assign ctrl_word = {27'h0, ctrl_r.ports, ctrl_r.ilace, ctrl_r.gate,
        ctrl_r.pol, ctrl_r.standby};
    assign ctrl_new = (ctrl_word & ~wmask) | (WB_DAT_IN & wmask);

    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            ctrl_r <= dbpc_pkg::CTRL_RST[4:0];
            meas_r <= 2'h0;
            ramp_r <= 15'h0000;
            parab_r <= 15'h0000;
            beam_r <= 8'h00;
            port_dat_r <= 7'h00;
            port_dir_r <= 7'h00;
        end else if (wb_wr) begin
            case (WB_ADR_IN)
                dbpc_pkg::CTRL_OFS: begin
                    ctrl_r.standby <= ctrl_new[dbpc_pkg::CTRL_STANDBY];
                    ctrl_r.pol <= ctrl_new[dbpc_pkg::CTRL_POL];
                    ctrl_r.gate <= ctrl_new[dbpc_pkg::CTRL_GATE];
                    ctrl_r.ilace <= ctrl_new[dbpc_pkg::CTRL_ILACE];
                    ctrl_r.ports <= ctrl_new[dbpc_pkg::CTRL_PORTS];
                end
                dbpc_pkg::MEAS_OFS: begin
                    if (WB_SEL_IN[0]) begin
                        meas_r <= WB_DAT_IN[1:0];
                    end
                end
                dbpc_pkg::RAMP_OFS: begin
                    if (WB_SEL_IN[0]) begin
                        ramp_r[7:0] <= WB_DAT_IN[7:0];
                    end
                    if (WB_SEL_IN[1]) begin
                        ramp_r[14:8] <= WB_DAT_IN[14:8];
                    end
                end
                dbpc_pkg::PARAB_OFS: begin
                    if (WB_SEL_IN[0]) begin
                        parab_r[7:0] <= WB_DAT_IN[7:0];
                    end
                    if (WB_SEL_IN[1]) begin
                        parab_r[14:8] <= WB_DAT_IN[14:8];
                    end
                end
                dbpc_pkg::BEAM_OFS: begin
                    if (WB_SEL_IN[0]) begin
                        beam_r <= WB_DAT_IN[7:0];
                    end
                end
                dbpc_pkg::PORT_OFS: begin
                    if (WB_SEL_IN[0]) begin
                        port_dat_r <= WB_DAT_IN[6:0];
                    end
                    if (WB_SEL_IN[1]) begin
                        port_dir_r <= WB_DAT_IN[14:8];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Lookup table has no reset; software loads it before use
    always_ff @(posedge CLK_SYS_IN) begin
        if (wb_wr && WB_ADR_IN == dbpc_pkg::CLUT_OFS && WB_SEL_IN[0] &&
            WB_SEL_IN[1] && WB_SEL_IN[2]) begin
            clut[WB_DAT_IN[dbpc_pkg::CLUT_IDX_LSB +: 5]] <= WB_DAT_IN[11:0];
        end
    end

    // ------------------------------------------------------------
    // Synchronisers for asynchronous analog-derived levels
    // ------------------------------------------------------------
    logic [1:0] safe_s1_r;
    logic [1:0] safe_s2_r;
    logic guard_s1_r;
    logic guard_s2_r;
    logic guard_s3_r;

    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            safe_s1_r <= 2'h0;
            safe_s2_r <= 2'h0;
            guard_s1_r <= 1'b0;
            guard_s2_r <= 1'b0;
            guard_s3_r <= 1'b0;
        end else begin
            safe_s1_r <= SAFETY_LEVEL_IN;
            safe_s2_r <= safe_s1_r;
            guard_s1_r <= RAMP_OUT_A_GUARD_IN;
            guard_s2_r <= guard_s1_r;
            guard_s3_r <= guard_s2_r;
        end
    end

    dbpc_pkg::dbpc_safe_t safe_lvl;
    always_comb begin
        case (safe_s2_r)
            2'b00: safe_lvl = dbpc_pkg::DBPC_SAFE_NORMAL;
            2'b01: safe_lvl = dbpc_pkg::DBPC_SAFE_BLANK;
            default: safe_lvl = dbpc_pkg::DBPC_SAFE_SHUT;
        endcase
    end

    // ------------------------------------------------------------
    // Vertical guard and field flag
    // ------------------------------------------------------------
    logic vb_d_r;
    logic edge_seen_r;
    logic guard_fault_r;
    logic vb_end;
    logic vb_start;

    assign vb_start = RAMP_OUT_A_BLANK_IN && !vb_d_r;
    assign vb_end = !RAMP_OUT_A_BLANK_IN && vb_d_r;

    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            vb_d_r <= 1'b0;
            edge_seen_r <= 1'b0;
            guard_fault_r <= 1'b0;
        end else begin
            vb_d_r <= RAMP_OUT_A_BLANK_IN;
            if (vb_start) begin
                edge_seen_r <= 1'b0;
            end else if (RAMP_OUT_A_BLANK_IN && guard_s3_r && !guard_s2_r) begin
                edge_seen_r <= 1'b1;
            end
            if (vb_end) begin
                guard_fault_r <= !edge_seen_r;
            end
        end
    end

    // Sticky fault event, write one to clear; a new event wins
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            guard_ev_r <= 1'b0;
        end else if (vb_end && !edge_seen_r) begin
            guard_ev_r <= 1'b1;
        end else if (wb_wr && WB_ADR_IN == dbpc_pkg::STAT_OFS &&
            WB_SEL_IN[0] && WB_DAT_IN[dbpc_pkg::STAT_GUARD_EV]) begin
            guard_ev_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            FIELD_PARITY_OUT <= 1'b0;
        end else if (!ctrl_r.ilace || ctrl_r.standby) begin
            FIELD_PARITY_OUT <= 1'b0;
        end else if (vb_start) begin
            FIELD_PARITY_OUT <= !FIELD_PARITY_OUT;
        end
    end

    // ------------------------------------------------------------
    // Line drive, runs in standby too
    // ------------------------------------------------------------
    logic [15:0] line_cnt_r;
    logic pulse_on;
    logic drive_active;

    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            line_cnt_r <= 16'h0000;
        end else if (line_cnt_r == 16'(LINE_CYCLES - 1)) begin
            line_cnt_r <= 16'h0000;
        end else begin
            line_cnt_r <= line_cnt_r + 16'h0001;
        end
    end

    assign pulse_on = line_cnt_r < 16'(PULSE_CYCLES);
    assign drive_active = pulse_on &&
        (safe_lvl != dbpc_pkg::DBPC_SAFE_SHUT) &&
        !(ctrl_r.gate && LINE_RETRACE_IN);

    // selectable polarity; pulling low is the open-drain active
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            LINE_DRIVE_OUT <= 1'b0;
            LINE_DRIVE_OE_OUT <= 1'b0;
        end else begin
            LINE_DRIVE_OUT <= 1'b0;
            LINE_DRIVE_OE_OUT <= drive_active ^ ctrl_r.pol;
        end
    end

    // ------------------------------------------------------------
    // Picture bus and RGB path
    // ------------------------------------------------------------
    logic [4:0] colour_addr;
    logic half_sel;
    dbpc_pkg::dbpc_pix_t pix_r;

    genvar gc;
    generate
        for (gc = 0; gc < 5; gc++) begin : g_col
            assign colour_addr[gc] = PORT_PINS_IN[6 - gc];
        end
    endgenerate
    assign half_sel = !ctrl_r.ports && PORT_PINS_IN[0];

    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            pix_r <= '0;
        end else begin
            pix_r.blank <= guard_fault_r || ctrl_r.standby ||
                (safe_lvl != dbpc_pkg::DBPC_SAFE_NORMAL);
            pix_r.half <= half_sel;
            pix_r.ext1 <= EXT_RGB_SWITCH_IN[0];
            pix_r.ext2 <= EXT_RGB_SWITCH_IN[1];
            pix_r.src <= SOURCE_PRIORITY_LINES_IN;
            if (ctrl_r.ports) begin
                pix_r.rgb <= 12'h000;
            end else begin
                pix_r.rgb <= clut[colour_addr];
            end
        end
    end

    assign RGB_BLANK_OUT = pix_r.blank;
    assign RGB_HALF_LEVEL_OUT = pix_r.half;
    assign RGB_EXT_SELECT_OUT = {pix_r.ext2, pix_r.ext1};
    assign SOURCE_SELECT_OUT = pix_r.src;
    assign RGB_CODE_OUT = pix_r.rgb;

    // ------------------------------------------------------------
    // Deflection converters, frozen in standby; beam speed output forced to BEAM_MID in standby
    // ------------------------------------------------------------
    logic run_en;
    assign run_en = !ctrl_r.standby;

    dbpc_shaper #(
        .IN_W(dbpc_pkg::DAC_IN_W),
        .OUT_W(dbpc_pkg::DAC_OUT_W)
    ) u_ramp (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(RESETN_IN),
        .en_in(run_en),
        .val_in(ramp_r),
        .code_out(RAMP_OUT_A_OUT)
    );

    dbpc_shaper #(
        .IN_W(dbpc_pkg::DAC_IN_W),
        .OUT_W(dbpc_pkg::DAC_OUT_W)
    ) u_parab (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(RESETN_IN),
        .en_in(run_en),
        .val_in(parab_r),
        .code_out(PINCUSHION_PARABOLA_OUT)
    );

    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            BEAM_SPEED_MOD_OUT <= dbpc_pkg::BEAM_MID;
        end else if (ctrl_r.standby) begin
            BEAM_SPEED_MOD_OUT <= dbpc_pkg::BEAM_MID;
        end else begin
            BEAM_SPEED_MOD_OUT <= beam_r ^ dbpc_pkg::BEAM_MID;
        end
    end

    // ------------------------------------------------------------
    // Measurement range switches, oe high pulls the pin low
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            MEAS_RANGE_SW_A_OUT <= 1'b0;
            MEAS_RANGE_SW_A_OE_OUT <= 1'b1;
            MEAS_RANGE_SW_B_OUT <= 1'b0;
            MEAS_RANGE_SW_B_OE_OUT <= 1'b1;
        end else begin
            MEAS_RANGE_SW_A_OUT <= 1'b0;
            MEAS_RANGE_SW_B_OUT <= 1'b0;
            MEAS_RANGE_SW_A_OE_OUT <= !(meas_r[dbpc_pkg::MEAS_CUTOFF] ||
                meas_r[dbpc_pkg::MEAS_WHITE]);
            MEAS_RANGE_SW_B_OE_OUT <= !meas_r[dbpc_pkg::MEAS_CUTOFF];
        end
    end

    // ------------------------------------------------------------
    // Port expander
    // ------------------------------------------------------------
    // shared pins as port
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            PORT_PINS_OUT <= 7'h00;
            PORT_PINS_OE_OUT <= 7'h00;
        end else begin
            PORT_PINS_OUT <= port_dat_r;
            PORT_PINS_OE_OUT <= ctrl_r.ports ? port_dir_r : 7'h00;
        end
    end

    // ------------------------------------------------------------
    // Clock outputs
    // ------------------------------------------------------------
    // A flop cannot carry the full rate; this is the nearest registered
    // copy of the system clock, at half rate.
    logic [1:0] mcu_cnt_r;
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            SYS_CLK_OUT <= 1'b0;
            MCU_CLK_OUT <= 1'b0;
            mcu_cnt_r <= 2'h0;
        end else begin
            SYS_CLK_OUT <= !SYS_CLK_OUT;
            if (mcu_cnt_r == 2'(dbpc_pkg::MCU_HALF_CYC - 1)) begin
                mcu_cnt_r <= 2'h0;
                MCU_CLK_OUT <= !MCU_CLK_OUT;
            end else begin
                mcu_cnt_r <= mcu_cnt_r + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus read and acknowledge
    // ------------------------------------------------------------
    always_comb begin
        case (WB_ADR_IN)
            dbpc_pkg::CTRL_OFS: rdata = ctrl_word;
            dbpc_pkg::MEAS_OFS: rdata = {30'h0, meas_r};
            dbpc_pkg::RAMP_OFS: rdata = {17'h0, ramp_r};
            dbpc_pkg::PARAB_OFS: rdata = {17'h0, parab_r};
            dbpc_pkg::BEAM_OFS: rdata = {24'h0, beam_r};
            dbpc_pkg::PORT_OFS: rdata = {9'h000, PORT_PINS_IN, 1'b0,
                port_dir_r, 1'b0, port_dat_r};
            dbpc_pkg::STAT_OFS: rdata = {24'h0, safe_s2_r,
                FIELD_PARITY_OUT, SOURCE_PRIORITY_LINES_IN,
                guard_fault_r, guard_ev_r};
            default: rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            WB_ACK_OUT <= 1'b0;
            WB_DAT_OUT <= 32'h0000_0000;
        end else begin
            WB_ACK_OUT <= wb_req;
            WB_DAT_OUT <= wb_req ? rdata : 32'h0000_0000;
        end
    end
endmodule : dbpc_top

// file: dbpc_chk.sv
// Port checks for the display back-end pin control block.
// Assumes a bind into dbpc_top and a single clock domain.
`timescale 1ns/1ps
module dbpc_chk (
    input wire logic CLK_SYS_IN, RESETN_IN,
    input wire logic WB_CYC_IN, WB_STB_IN, WB_ACK_OUT,
    input wire logic [1:0] SAFETY_LEVEL_IN,
    input wire logic [2:0] SOURCE_PRIORITY_LINES_IN, SOURCE_SELECT_OUT,
    input wire logic RGB_BLANK_OUT, LINE_DRIVE_OE_OUT,
    input wire logic MEAS_RANGE_SW_A_OE_OUT, MEAS_RANGE_SW_B_OE_OUT,
    input wire logic SYS_CLK_OUT, MCU_CLK_OUT
);
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RESETN_IN);
    chk_ack_next: assert property (
        WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
        else $error("bus request not acknowledged next cycle");
    chk_ack_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("acknowledge longer than one cycle");
    chk_sw_nest: assert property (
        !MEAS_RANGE_SW_B_OE_OUT |-> !MEAS_RANGE_SW_A_OE_OUT)
        else $error("switch B released while switch A pulled");
    chk_src_follow: assert property (
        !RGB_BLANK_OUT |-> SOURCE_SELECT_OUT ==
        $past(SOURCE_PRIORITY_LINES_IN))
        else $error("source select not resampled each cycle");
    chk_safe_blank: assert property (
        (SAFETY_LEVEL_IN == 2'h1) [*5] |-> RGB_BLANK_OUT)
        else $error("medium safety level did not blank");
    chk_shut_blank: assert property (
        SAFETY_LEVEL_IN[1] [*5] |-> RGB_BLANK_OUT)
        else $error("high safety level did not blank");
    chk_shut_drive: assert property (
        SAFETY_LEVEL_IN[1] [*7] |-> $stable(LINE_DRIVE_OE_OUT))
        else $error("line drive pulsing at high safety level");
    chk_sys_toggle: assert property (
        $past(RESETN_IN) |-> SYS_CLK_OUT != $past(SYS_CLK_OUT))
        else $error("system clock output stalled");
    chk_mcu_rate: assert property (
        $changed(MCU_CLK_OUT) |=> $stable(MCU_CLK_OUT) ##1
        $changed(MCU_CLK_OUT))
        else $error("controller clock not a quarter rate");
endmodule : dbpc_chk
bind dbpc_top dbpc_chk i_chk (.CLK_SYS_IN, .RESETN_IN, .WB_CYC_IN,
    .WB_STB_IN, .WB_ACK_OUT, .SAFETY_LEVEL_IN, .SOURCE_PRIORITY_LINES_IN,
    .SOURCE_SELECT_OUT, .RGB_BLANK_OUT, .LINE_DRIVE_OE_OUT,
    .MEAS_RANGE_SW_A_OE_OUT, .MEAS_RANGE_SW_B_OE_OUT, .SYS_CLK_OUT,
    .MCU_CLK_OUT);

// file: dbpc_partner.sv
// Far-side model: field blanking and the vertical guard comparator.
// Assumes frame_in is a one-cycle request from the bench.
`timescale 1ns/1ps
module dbpc_partner (
    input wire logic clk_in,
    input wire logic frame_in,
    input wire logic fault_in,
    output logic vblank_out,
    output logic guard_out
);
    logic [3:0] cnt_r = 4'h0;
    always_ff @(posedge clk_in) begin
        if (frame_in && cnt_r == 4'h0)
            cnt_r <= 4'hC;
        else if (cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
    end
    assign vblank_out = cnt_r > 4'h2;
    // guard falls mid-blank unless stage faulty
    assign guard_out = fault_in || cnt_r > 4'h7 || cnt_r == 4'h0;
endmodule : dbpc_partner

// file: dbpc_top_tb_top.sv
// Scenario bench for the display back-end pin control block.
// Assumes the checker is bound and the far-side model compiled first.
`timescale 1ns/1ps
module dbpc_top_tb_top;
    logic CLK_SYS_IN = 1'b0, RESETN_IN = 1'b0, LINE_RETRACE_IN = 1'b0;
    logic WB_CYC_IN = 1'b0, WB_STB_IN = 1'b0, WB_WE_IN = 1'b0, WB_ACK_OUT;
    logic [7:0] WB_ADR_IN = 8'h00, BEAM_SPEED_MOD_OUT;
    logic [31:0] WB_DAT_IN = 32'h0, WB_DAT_OUT, rd;
    logic [1:0] SAFETY_LEVEL_IN = 2'h0, EXT_RGB_SWITCH_IN = 2'h0;
    logic [2:0] SOURCE_PRIORITY_LINES_IN = 3'h0, SOURCE_SELECT_OUT;
    logic [6:0] PORT_PINS_IN = 7'h00, PORT_PINS_OUT, PORT_PINS_OE_OUT;
    logic [3:0] RAMP_OUT_A_OUT, PINCUSHION_PARABOLA_OUT;
    logic [1:0] RGB_EXT_SELECT_OUT;
    logic [11:0] RGB_CODE_OUT;
    logic RGB_BLANK_OUT, RGB_HALF_LEVEL_OUT, FIELD_PARITY_OUT;
    logic LINE_DRIVE_OE_OUT, MEAS_RANGE_SW_A_OE_OUT, MEAS_RANGE_SW_B_OE_OUT;
    logic RAMP_OUT_A_BLANK_IN, RAMP_OUT_A_GUARD_IN, frame = 1'b0, fault = 1'b0;
    int failures = 0, tests_run = 0, cycles = 0;
    dbpc_top #(.LINE_CYCLES(16), .PULSE_CYCLES(7)) i_dut (.CLK_SYS_IN,
        .RESETN_IN, .WB_CYC_IN, .WB_STB_IN, .WB_WE_IN, .WB_ADR_IN,
        .WB_SEL_IN(4'hF), .WB_DAT_IN, .WB_DAT_OUT, .WB_ACK_OUT,
        .RAMP_OUT_A_BLANK_IN, .RAMP_OUT_A_GUARD_IN, .SAFETY_LEVEL_IN, .LINE_RETRACE_IN,
        .SOURCE_PRIORITY_LINES_IN, .EXT_RGB_SWITCH_IN, .PORT_PINS_IN,
        .PORT_PINS_OUT, .PORT_PINS_OE_OUT, .RGB_BLANK_OUT,
        .RGB_HALF_LEVEL_OUT, .RGB_EXT_SELECT_OUT, .SOURCE_SELECT_OUT,
        .RGB_CODE_OUT, .FIELD_PARITY_OUT, .LINE_DRIVE_OUT(),
        .LINE_DRIVE_OE_OUT, .RAMP_OUT_A_OUT, .PINCUSHION_PARABOLA_OUT,
        .BEAM_SPEED_MOD_OUT, .MEAS_RANGE_SW_A_OUT(), .MEAS_RANGE_SW_A_OE_OUT,
        .MEAS_RANGE_SW_B_OUT(), .MEAS_RANGE_SW_B_OE_OUT, .SYS_CLK_OUT(),
        .MCU_CLK_OUT());
    dbpc_partner i_far (.clk_in(CLK_SYS_IN), .frame_in(frame),
        .fault_in(fault), .vblank_out(RAMP_OUT_A_BLANK_IN),
        .guard_out(RAMP_OUT_A_GUARD_IN));
    // bench clock stands in for the crystal; tuning stays unused
    initial forever #25 CLK_SYS_IN = ~CLK_SYS_IN;
    // Run is about 400 cycles; the ceiling leaves ample margin
    always @(posedge CLK_SYS_IN) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        WB_CYC_IN <= 1'b1;
        WB_STB_IN <= 1'b1;
        WB_WE_IN <= w;
        WB_ADR_IN <= a;
        WB_DAT_IN <= d;
        do @(posedge CLK_SYS_IN); while (WB_ACK_OUT !== 1'b1);
        rd = WB_DAT_OUT;
        WB_CYC_IN <= 1'b0;
        WB_STB_IN <= 1'b0;
        @(posedge CLK_SYS_IN);
    endtask : bus
    task automatic t_meas;
        chk(BEAM_SPEED_MOD_OUT, 8'h80);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, 8'h04, m);
            @(posedge CLK_SYS_IN);
            chk(MEAS_RANGE_SW_A_OE_OUT, m == 0);
            chk(MEAS_RANGE_SW_B_OE_OUT, m[0] == 1'b0);
        end
        $display("meas done");
    endtask : t_meas
    task automatic t_pix;
        for (logic [3:0] i = 4'h0; i < 4'h8; i++) begin
            SOURCE_PRIORITY_LINES_IN <= i[2:0];
            EXT_RGB_SWITCH_IN <= i[1:0];
            PORT_PINS_IN <= {6'h00, i[2]};
            repeat (2) @(posedge CLK_SYS_IN);
            chk(SOURCE_SELECT_OUT, i[2:0]);
            chk(RGB_EXT_SELECT_OUT, i[1:0]);
            chk(RGB_HALF_LEVEL_OUT, i[2]);
        end
        bus(1'b0, 8'h1C, 32'h0);
        chk(rd[4:2], 3'h7);
        bus(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 8'h18, 32'h0005_0ABC);
        PORT_PINS_IN <= 7'h50;
        repeat (4) @(posedge CLK_SYS_IN);
        chk(RGB_CODE_OUT, 12'hABC);
        $display("pixel done");
    endtask : t_pix
    task automatic t_dac;
        bus(1'b1, 8'h08, 32'h5800);
        bus(1'b1, 8'h0C, 32'h2800);
        bus(1'b1, 8'h14, 32'h7F55);
        bus(1'b1, 8'h00, 32'h10);
        @(posedge CLK_SYS_IN);
        chk(RAMP_OUT_A_OUT, 4'hB);
        chk(PINCUSHION_PARABOLA_OUT, 4'h5);
        chk(PORT_PINS_OUT, 7'h55);
        chk(PORT_PINS_OE_OUT, 7'h7F);
        $display("dac done");
    endtask : t_dac
    task automatic t_frame(input logic f, input logic fld);
        fault <= f;
        frame <= 1'b1;
        @(posedge CLK_SYS_IN);
        frame <= 1'b0;
        repeat (20) @(posedge CLK_SYS_IN);
        chk(RGB_BLANK_OUT, f);
        chk(FIELD_PARITY_OUT, fld);
        $display("frame done");
    endtask : t_frame
    task automatic t_line(input logic [31:0] c, input logic [1:0] s,
                          input logic r, input int e);
        int n;
        n = 0;
        SAFETY_LEVEL_IN <= 2'h0;
        repeat (7) @(posedge CLK_SYS_IN);
        bus(1'b1, 8'h00, c);
        SAFETY_LEVEL_IN <= s;
        LINE_RETRACE_IN <= r;
        repeat (8) @(posedge CLK_SYS_IN);
        for (int i = 0; i < 16; i++) begin
            @(posedge CLK_SYS_IN);
            n += LINE_DRIVE_OE_OUT;
        end
        chk(n, e);
        chk(RGB_BLANK_OUT, s != 2'h0 || c[0]);
        $display("line done");
    endtask : t_line
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done
    initial begin
        repeat (4) @(posedge CLK_SYS_IN);
        RESETN_IN <= 1'b1;
        @(posedge CLK_SYS_IN);
        t_meas();
        t_pix();
        t_dac();
        bus(1'b1, 8'h00, 32'h8);
        t_frame(1'b0, 1'b1);
        t_frame(1'b1, 1'b0);
        t_frame(1'b0, 1'b1);
        t_line(32'h0, 2'h0, 1'b0, 7);
        t_line(32'h0, 2'h2, 1'b0, 0);
        t_line(32'h4, 2'h0, 1'b1, 0);
        t_line(32'h4, 2'h0, 1'b0, 7);
        t_line(32'h2, 2'h0, 1'b0, 9);
        t_line(32'h2, 2'h2, 1'b0, 16);
        t_line(32'h0, 2'h1, 1'b0, 7);
        t_line(32'h1, 2'h0, 1'b0, 7);
        test_done();
    end
endmodule : dbpc_top_tb_top
